// File: bench/pfs_ext_model.sv
// external system model: event pins, test select and the shared reset wire
// assumes the bench calls its tasks; the reset wire has a pull-up
`timescale 1ns/10ps
module pfs_ext_model (
	input wire logic clk_sys, // state-time clock
	input wire logic pinResetOe, // device pulls reset low
	output logic [6:0] evPins, // p07, p22, nmi, hsi0..3
	output logic pinTestSelIn, // test select level
	output logic pinResetIn_n // resolved reset wire
);
	logic extRst_n;
	// open drain wire: either party may pull it low
	assign pinResetIn_n = pinResetOe ? 1'b0 : extRst_n;
	initial begin
		evPins = 7'h00;
		pinTestSelIn = 1'b0;
		extRst_n = 1'b0;
	end
	task automatic pulse(input int idx, input int len);
		int n;
		// never shorter than the minimum hold, so no edge can be lost
		n = (idx == 2) ? 1 : 2;
		if (len > n)
			n = len;
		@(negedge clk_sys);
		evPins[idx] = 1'b1;
		repeat (n) @(negedge clk_sys);
		evPins[idx] = 1'b0;
	endtask
	task automatic reset_pin(input int len, input logic test);
		@(negedge clk_sys);
		pinTestSelIn = test;
		extRst_n = 1'b0;
		repeat (len) @(negedge clk_sys);
		extRst_n = 1'b1;
	endtask
endmodule

// File: bench/pfs_pin_mux_tb_top.sv
// self-checking bench for the pin function select block
// assumes one state time per clk_sys cycle and pulses counted at falling edges
`timescale 1ns/10ps
module pfs_pin_mux_tb_top;
	typedef struct packed {
		logic [2:0] pin;
		logic pd;
		logic [7:0] c0, c1, c3, m1, m, exp;
		logic [15:0] vec;
	} pfs_row_s;
	logic clk_sys, arst_n, clkEn, powerDown, portP2Out0, serialTx, serialRxOut, pinRxIn;
	logic [7:0] ioControl0, ioControl1, ioControl2, ioControl3, serialControl;
	logic [7:0] interruptMask1, interruptMask, pulseControl1, pulseControl2;
	logic [1:0] serialMode, portP1Out, hsoCore, pinP1Out, pinHsoOut, pinHsoOe;
	logic [6:0] evPins;
	logic pinTestSelIn, pinResetIn_n, pinResetOe, pinRxOut, pinRxOe, pinTxOut;
	logic extIntReq, extInt1Req, nmiReq, hsi0IntReq, timer2Reset, timer2ClkTick, wakeUp;
	logic coreReset, testMode, rxData, portP21In;
	logic [3:0] hsiEvent;
	logic [15:0] intVector;
	logic [7:0] evSigs;
	int n_mismatch = 0;
	int n_compared = 0;
	int cnt[8];
	pfs_row_s rows[13] = '{
		'{3'd0, 1'b0, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 16'h200e},
		'{3'd0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000},
		'{3'd1, 1'b0, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h03, 16'h203a},
		'{3'd1, 1'b0, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000},
		'{3'd2, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 16'h203e},
		'{3'd3, 1'b0, 8'h01, 8'h00, 8'h00, 8'h00, 8'h10, 8'h18, 16'h2008},
		'{3'd3, 1'b0, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 16'h0000},
		'{3'd4, 1'b0, 8'h84, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 16'h0000},
		'{3'd4, 1'b0, 8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 16'h0000},
		'{3'd0, 1'b1, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h81, 16'h200e},
		'{3'd1, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 16'h200e},
		'{3'd5, 1'b0, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 16'h0000},
		'{3'd6, 1'b0, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 16'h0000}
	};
	assign evSigs = {wakeUp, timer2ClkTick, timer2Reset, |hsiEvent, hsi0IntReq, nmiReq,
		extInt1Req, extIntReq};
	pfs_ext_model i_ext (.clk_sys, .pinResetOe, .evPins, .pinTestSelIn, .pinResetIn_n);
	pfs_pin_mux i_dut (.clk_sys, .arst_n, .clkEn, .ioControl0, .ioControl1, .ioControl2,
		.ioControl3, .serialControl, .interruptMask1, .interruptMask, .serialMode,
		.pulseControl1, .pulseControl2, .powerDown, .portP2Out0, .portP1Out, .serialTx,
		.serialRxOut, .hsoCore, .pinP07(evPins[0]), .pinP22(evPins[1]), .pinNmi(evPins[2]),
		.pinHsi(evPins[6:3]), .pinRxIn, .pinTestSelIn, .pinResetIn_n, .pinResetOe, .pinRxOut,
		.pinRxOe, .pinTxOut, .pinP1Out, .pinHsoOut, .pinHsoOe, .extIntReq, .extInt1Req,
		.nmiReq, .hsi0IntReq, .hsiEvent, .timer2Reset, .timer2ClkTick, .wakeUp, .coreReset,
		.testMode, .rxData, .portP21In, .intVector);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// counts every one-cycle pulse; two pulses for one edge show up as count 2
	task automatic observe(input int n, output logic [15:0] packedCnt);
		for (int i = 0; i < 8; i++)
			cnt[i] = 0;
		repeat (n) begin
			@(negedge clk_sys);
			for (int i = 0; i < 8; i++)
				cnt[i] += (evSigs[i] === 1'b1);
		end
		for (int i = 0; i < 8; i++)
			packedCnt[2*i +: 2] = (cnt[i] > 3) ? 2'd3 : 2'(cnt[i]);
	endtask
	function automatic logic [15:0] spread(input logic [7:0] e);
		for (int i = 0; i < 8; i++)
			spread[2*i +: 2] = {1'b0, e[i]};
	endfunction
	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#30000;
		n_mismatch++;
		conclude();
	end
	initial begin
		logic [15:0] seen;
		{arst_n, clkEn, powerDown, portP2Out0, serialTx, serialRxOut, pinRxIn} = 7'b0100000;
		{ioControl0, ioControl1, ioControl2, ioControl3, serialControl} = 40'h0;
		{interruptMask1, interruptMask, pulseControl1, pulseControl2} = 32'h0080_4000;
		{serialMode, portP1Out, hsoCore} = 6'b01_00_00;
		repeat (2) @(negedge clk_sys);
		arst_n = 1'b1;
		i_ext.reset_pin(20, 1'b0);
		repeat (5) @(negedge clk_sys);
		check("cold release", {coreReset, testMode}, 2'b01);
		$display("test cold reset done");
		foreach (rows[r]) begin
			{ioControl0, ioControl1, ioControl3} = {rows[r].c0, rows[r].c1, rows[r].c3};
			{interruptMask1, interruptMask, powerDown} = {rows[r].m1, rows[r].m, rows[r].pd};
			repeat (3) @(negedge clk_sys);
			fork
				i_ext.pulse(rows[r].pin, 3);
				observe(12, seen);
			join
			check("event counts", seen, spread(rows[r].exp));
			if (rows[r].vec != 16'h0)
				check("vector", intVector, rows[r].vec);
			$display("test row %0d done", r);
		end
		{powerDown, ioControl0, interruptMask1, interruptMask} = 25'h0;
		{ioControl1, ioControl3, serialControl, serialMode} = {8'h20, 8'h0c, 8'h08, 2'h0};
		{serialTx, portP2Out0, portP1Out, pinRxIn, serialRxOut} = 6'b0_1_11_1_0;
		repeat (4) @(negedge clk_sys);
		check("tx pin", pinTxOut, 1'b0);
		check("p1 pins", pinP1Out[1], 1'b0);
		check("rx data", rxData, 1'b1);
		check("rx drive", {pinRxOe, pinRxOut}, 2'b10);
		cnt[0] = 0;
		repeat (256) begin
			@(negedge clk_sys);
			cnt[0] += pinP1Out[0];
		end
		check("pulse_output_1 duty", 16'(cnt[0]), 16'd64);
		ioControl2 = 8'h04;
		repeat (2) @(negedge clk_sys);
		cnt[0] = 0;
		repeat (512) begin
			@(negedge clk_sys);
			cnt[0] += pinP1Out[0];
		end
		check("pulse_output_1 slow duty", 16'(cnt[0]), 16'd128);
		{ioControl1, ioControl2, ioControl3, serialControl} = 32'h0;
		repeat (4) @(negedge clk_sys);
		check("port out", pinTxOut, 1'b1);
		check("port in", {portP21In, rxData}, 2'b10);
		check("p1 port", pinP1Out, 2'b11);
		{clkEn, portP2Out0} = 2'b00;
		repeat (3) @(negedge clk_sys);
		check("frozen", pinTxOut, 1'b1);
		clkEn = 1'b1;
		repeat (2) @(negedge clk_sys);
		check("thawed", pinTxOut, 1'b0);
		{ioControl0, ioControl1} = 16'h1010;
		repeat (3) @(negedge clk_sys);
		hsoCore = 2'b01;
		observe(8, seen);
		check("hso drive", {pinHsoOe, pinHsoOut}, 4'b0101);
		check("hso seen", seen, spread(8'h10));
		$display("test routing done");
		i_ext.reset_pin(1, 1'b1);
		cnt[0] = 0;
		repeat (30) begin
			@(negedge clk_sys);
			cnt[0] += pinResetOe;
		end
		check("stretch", 16'(cnt[0]), 16'd16);
		check("warm release", {coreReset, testMode}, 2'b00);
		$display("test warm reset done");
		conclude();
	end
endmodule

// File: hdl/pfs_defines.svh
// constants for the pin function select block: control bit positions, vectors, timing
// assumes one state time equals one clk_sys cycle at 100 MHz
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
`define PFS_IO_CONTROL_0_HSI0_EN 0
`define PFS_IO_CONTROL_0_HSI1_EN 2
`define PFS_IO_CONTROL_0_TIMER2_RESET_INPUT_EN 3
`define PFS_IO_CONTROL_0_HSI2_EN 4
`define PFS_IO_CONTROL_0_TIMER2_RESET_INPUT_SEL 5
`define PFS_IO_CONTROL_0_HSI3_EN 6
`define PFS_IO_CONTROL_0_TIMER2_CLOCK_INPUT_SEL 7
`define PFS_IO_CONTROL_1_EXT_SEL 1
`define PFS_IO_CONTROL_1_HSO4_EN 4
`define PFS_IO_CONTROL_1_TXD_EN 5
`define PFS_IO_CONTROL_1_HSO5_EN 6
`define PFS_IO_CONTROL_2_PWM_FREQ 2
`define PFS_IO_CONTROL_3_T2_INTCLK 0
`define PFS_IO_CONTROL_3_PULSE_OUTPUT_1_EN 2
`define PFS_IO_CONTROL_3_PULSE_OUTPUT_2_EN 3
`define PFS_SERIAL_CONTROL_RXD_EN 3
`define PFS_MASK1_EXT1 5
`define PFS_MASK_HSI0 4
`define PFS_VEC_EXTERNAL_INTERRUPT_INPUT 16'h200e
`define PFS_VEC_SECOND_EXTERNAL_INTERRUPT 16'h203a
`define PFS_VEC_NMI 16'h203e
`define PFS_VEC_HSI0 16'h2008
`define PFS_STATE_NS 10
`define PFS_RST_STRETCH_ST 16
`define PFS_RST_FIRST_ST 16
`define PFS_RST_STRETCH_CYC ((`PFS_RST_STRETCH_ST * `PFS_STATE_NS + 9) / 10)
`endif

// File: hdl/pfs_edge_sync.sv
// two-flop synchroniser with rising-edge detect, one per external input
// assumes asynchronous inputs; first flop is read only by the second
`timescale 1ns/10ps
module pfs_edge_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys, // state-time clock
	input wire logic arst_n, // async reset, active low
	input wire logic clkEn, // freeze when low
	input wire logic [WIDTH-1:0] pinIn, // raw pins
	output logic [WIDTH-1:0] level, // synchronised level
	output logic [WIDTH-1:0] rise // one-cycle rising pulse
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] prev;
	} pfs_sync_s;
	pfs_sync_s state, next_state;
	always_comb begin
		next_state = state;
		if (clkEn) begin
			next_state.meta = pinIn;
			next_state.sync = state.meta;
			next_state.prev = state.sync;
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign level = state.sync;
	assign rise = state.sync & ~state.prev; // RQ23
endmodule

// File: hdl/pfs_pin_mux.sv
// pin function select and external event inputs
// How it works
// (RQ1) control_1 bit1 high: interrupt from port0 bit7
// (RQ2) control_1 bit1 low: interrupt from port2 bit2
// (RQ3) rising edge raises interrupt 7, vector 200e
// (RQ4) partner holds interrupt input two state times
// (RQ5) interrupt input wakes power down, ignoring mask
// (RQ6) rising non-maskable input vectors to 203e
// (RQ7) partner holds non-maskable input one state time
// (RQ8) port2 bit2 raises interrupt 13 unless masked
// (RQ9) first external reset lasts sixteen state times
// (RQ10) later resets stretched sixteen state times by device
// (RQ11) serial control bit3 selects receive or port
// (RQ12) receive pin open-drain data in mode 0
// (RQ13) control_1 bit5 selects transmit or port output
// (RQ14) test select low at reset release: test mode
// (RQ15) control_3 bits 2,3 route pulse outputs
// (RQ16) duty per register, frequency from control_2 bit2
// (RQ17) high-speed input 0 edge raises interrupt 4
// (RQ18) control_0 even bits enable high-speed inputs
// (RQ19) control_0 bits 3,5 give edge timer2 reset
// (RQ20) control_0 bit7, control_3 bit0 low: timer2 clock
// (RQ21) control_1 bits 4,6 enable high-speed outputs 4,5
// (RQ22) shared pins input sees own driven output
// (RQ23) inputs synchronised and edge-detected once
// assumes one state time per clk_sys cycle; serial and timer cores live outside, the pwm counter lives here
`include "pfs_defines.svh"
`timescale 1ns/10ps
module pfs_pin_mux #(
	parameter int PWM_W = 8 // duty register width
) (
	input wire logic clk_sys, // state-time clock
	input wire logic arst_n, // async reset, active low
	input wire logic clkEn, // freeze when low
	input wire logic [7:0] ioControl0, // io_control_0
	input wire logic [7:0] ioControl1, // io_control_1
	input wire logic [7:0] ioControl2, // io_control_2
	input wire logic [7:0] ioControl3, // io_control_3
	input wire logic [7:0] serialControl, // serial_control
	input wire logic [7:0] interruptMask1, // interrupt_mask_1
	input wire logic [7:0] interruptMask, // interrupt_mask
	input wire logic [1:0] serialMode, // serial mode 0..3
	input wire logic [PWM_W-1:0] pulseControl1, // pulse_control_1 duty
	input wire logic [PWM_W-1:0] pulseControl2, // pulse_control_2 duty
	input wire logic powerDown, // core in power down
	input wire logic portP2Out0, // port latch for port2 bit0
	input wire logic [1:0] portP1Out, // port latch for port1 bits 3,4
	input wire logic serialTx, // serial core transmit / clock
	input wire logic serialRxOut, // serial core mode0 data out
	input wire logic [1:0] hsoCore, // high-speed out 4,5 from core
	input wire logic pinP07, // port0 bit7 pin
	input wire logic pinP22, // port2 bit2 pin
	input wire logic pinNmi, // non-maskable interrupt pin
	input wire logic [3:0] pinHsi, // high-speed input pins
	input wire logic pinRxIn, // receive pin level
	input wire logic pinTestSelIn, // transmit / test_select_pin level
	input wire logic pinResetIn_n, // reset pin level
	output logic pinResetOe, // device pulls reset low
	output logic pinRxOut, // receive pin open-drain out
	output logic pinRxOe, // receive pin drive enable
	output logic pinTxOut, // transmit / port2 bit0 pin
	output logic [1:0] pinP1Out, // port1 bits 3,4 pins
	output logic [1:0] pinHsoOut, // high-speed out 4,5 pins
	output logic [1:0] pinHsoOe, // high-speed out 4,5 enables
	output logic extIntReq, // interrupt 7 pulse
	output logic extInt1Req, // interrupt 13 pulse
	output logic nmiReq, // non-maskable pulse
	output logic hsi0IntReq, // interrupt 4 pulse
	output logic [3:0] hsiEvent, // events to high-speed FIFO
	output logic timer2Reset, // timer2 reset pulse
	output logic timer2ClkTick, // timer2 external clock edge
	output logic wakeUp, // leave power down
	output logic coreReset, // internal reset active
	output logic testMode, // in-circuit test mode latched
	output logic rxData, // receive data to serial core
	output logic portP21In, // port2 bit1 input value
	output logic [15:0] intVector // vector of last event
);
	typedef struct packed {
		pfs_pkg::pfs_rst_e rstState;
		logic [4:0] rstCnt;
		logic pwmCycle;
		logic [PWM_W-1:0] pwmCnt;
		logic resetOe, rxOut, rxOe, txOut;
		logic [1:0] p1Out, hsoOut, hsoOe;
		logic extReq, ext1Req, nmi, hsi0Req;
		logic [3:0] hsiEv;
		logic timer2_reset_input, timer2_clock_input, wake, coreRst, test, rxd, p21;
		pfs_pkg::pfs_vec_t vector;
	} pfs_state_s;
	pfs_state_s state, next_state;
	// pins plus own high-speed drive folded in before sync
	logic [10:0] rawIn, syncLevel, syncRise;
	logic [3:0] hsiSeen;
	logic pulse_output_1, pulse_output_2, extSrcRise;
	assign hsiSeen = {pinHsi[3] | (state.hsoOe[1] & state.hsoOut[1]),
		pinHsi[2] | (state.hsoOe[0] & state.hsoOut[0]), pinHsi[1:0]}; // RQ22
	assign rawIn = {pinTestSelIn, pinResetIn_n, pinRxIn, hsiSeen, pinNmi, pinP22, pinP07, 1'b0};
	pfs_edge_sync #(
		.WIDTH(11)
	) u_sync (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.pinIn(rawIn),
		.level(syncLevel),
		.rise(syncRise)
	);
	assign pulse_output_1 = state.pwmCnt < pulseControl1; // RQ16
	assign pulse_output_2 = state.pwmCnt < pulseControl2; // RQ16
	assign extSrcRise = ioControl1[`PFS_IO_CONTROL_1_EXT_SEL] ? syncRise[1] : syncRise[2]; // RQ1 RQ2
	always_comb begin
		next_state = state;
		if (clkEn) begin
			// pwm counter, control_2 bit2 halves the rate
			next_state.pwmCycle = ~state.pwmCycle;
			if (!ioControl2[`PFS_IO_CONTROL_2_PWM_FREQ] || state.pwmCycle) begin
				next_state.pwmCnt = state.pwmCnt + {{(PWM_W-1){1'b0}}, 1'b1}; // RQ16
			end
			// reset pin: first reset needs the full length from outside
			next_state.resetOe = 1'b0;
			case (state.rstState)
				pfs_pkg::PFS_RST_COLD: begin
					next_state.coreRst = 1'b1;
					if (syncLevel[9]) begin
						if (state.rstCnt >= 5'(`PFS_RST_FIRST_ST)) begin // RQ9
							next_state.rstState = pfs_pkg::PFS_RST_RUN;
							next_state.coreRst = 1'b0;
							next_state.test = ~syncLevel[10]; // RQ14
						end
						next_state.rstCnt = '0;
					end else if (state.rstCnt < 5'(`PFS_RST_FIRST_ST)) begin
						next_state.rstCnt = state.rstCnt + 5'h01;
					end
				end
				pfs_pkg::PFS_RST_STRETCH: begin
					next_state.coreRst = 1'b1;
					next_state.resetOe = 1'b1;
					if (state.rstCnt == 5'(`PFS_RST_STRETCH_CYC - 1)) begin // RQ10
						// cold at full count: our own low still sits in the synchroniser
						next_state.rstState = pfs_pkg::PFS_RST_COLD;
						next_state.resetOe = 1'b0;
						next_state.rstCnt = 5'(`PFS_RST_FIRST_ST);
					end else begin
						next_state.rstCnt = state.rstCnt + 5'h01;
					end
				end
				pfs_pkg::PFS_RST_RUN: begin
					next_state.coreRst = 1'b0;
					if (!syncLevel[9]) begin
						// short pulse seen: hold the line low ourselves
						next_state.rstState = pfs_pkg::PFS_RST_STRETCH; // RQ10
						next_state.coreRst = 1'b1;
						next_state.resetOe = 1'b1;
						next_state.rstCnt = '0;
					end
				end
				default: next_state.rstState = pfs_pkg::PFS_RST_COLD;
			endcase
			// event requests, one cycle each
			next_state.extReq = extSrcRise; // RQ3
			next_state.ext1Req = syncRise[2] & interruptMask1[`PFS_MASK1_EXT1]; // RQ8
			next_state.nmi = syncRise[3]; // RQ6
			next_state.hsi0Req = syncRise[4] & interruptMask[`PFS_MASK_HSI0]; // RQ17
			next_state.wake = powerDown & extSrcRise; // RQ5
			next_state.hsiEv = syncRise[7:4] & {ioControl0[`PFS_IO_CONTROL_0_HSI3_EN],
				ioControl0[`PFS_IO_CONTROL_0_HSI2_EN], ioControl0[`PFS_IO_CONTROL_0_HSI1_EN],
				ioControl0[`PFS_IO_CONTROL_0_HSI0_EN]}; // RQ18
			next_state.timer2_reset_input = syncRise[4] & ioControl0[`PFS_IO_CONTROL_0_TIMER2_RESET_INPUT_EN]
				& ioControl0[`PFS_IO_CONTROL_0_TIMER2_RESET_INPUT_SEL]; // RQ19
			next_state.timer2_clock_input = syncRise[5] & ioControl0[`PFS_IO_CONTROL_0_TIMER2_CLOCK_INPUT_SEL]
				& ~ioControl3[`PFS_IO_CONTROL_3_T2_INTCLK]; // RQ20
			// nmi outranks the rest when several land together
			if (syncRise[3]) begin
				next_state.vector = `PFS_VEC_NMI;
			end else if (next_state.ext1Req) begin
				next_state.vector = `PFS_VEC_SECOND_EXTERNAL_INTERRUPT;
			end else if (extSrcRise) begin
				next_state.vector = `PFS_VEC_EXTERNAL_INTERRUPT_INPUT;
			end else if (next_state.hsi0Req) begin
				next_state.vector = `PFS_VEC_HSI0;
			end
			// pin routing
			next_state.rxd = serialControl[`PFS_SERIAL_CONTROL_RXD_EN] & syncLevel[8]; // RQ11 RQ12
			next_state.p21 = syncLevel[8];
			next_state.rxOe = serialControl[`PFS_SERIAL_CONTROL_RXD_EN] && serialMode == 2'h0
				&& !serialRxOut; // RQ12
			next_state.rxOut = 1'b0;
			next_state.txOut = ioControl1[`PFS_IO_CONTROL_1_TXD_EN] ? serialTx : portP2Out0; // RQ13
			next_state.p1Out[0] = ioControl3[`PFS_IO_CONTROL_3_PULSE_OUTPUT_1_EN] ? pulse_output_1 : portP1Out[0]; // RQ15
			next_state.p1Out[1] = ioControl3[`PFS_IO_CONTROL_3_PULSE_OUTPUT_2_EN] ? pulse_output_2 : portP1Out[1]; // RQ15
			next_state.hsoOe = {ioControl1[`PFS_IO_CONTROL_1_HSO5_EN],
				ioControl1[`PFS_IO_CONTROL_1_HSO4_EN]}; // RQ21
			next_state.hsoOut = hsoCore;
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
			state.rstState <= pfs_pkg::PFS_RST_COLD;
			state.coreRst <= 1'b1;
			state.txOut <= 1'b1;
			state.p1Out <= 2'h3;
			state.vector <= 16'h0000;
		end else begin
			state <= next_state;
		end
	end
	assign pinResetOe = state.resetOe;
	assign pinRxOut = state.rxOut;
	assign pinRxOe = state.rxOe;
	assign pinTxOut = state.txOut;
	assign pinP1Out = state.p1Out;
	assign pinHsoOut = state.hsoOut;
	assign pinHsoOe = state.hsoOe;
	assign extIntReq = state.extReq;
	assign extInt1Req = state.ext1Req;
	assign nmiReq = state.nmi;
	assign hsi0IntReq = state.hsi0Req;
	assign hsiEvent = state.hsiEv;
	assign timer2Reset = state.timer2_reset_input;
	assign timer2ClkTick = state.timer2_clock_input;
	assign wakeUp = state.wake;
	assign coreReset = state.coreRst;
	assign testMode = state.test;
	assign rxData = state.rxd;
	assign portP21In = state.p21;
	assign intVector = state.vector;
	// assertions
	property p_ext_pulse;
		@(posedge clk_sys) disable iff (!arst_n)
		clkEn && extSrcRise |=> extIntReq ##1 (!extIntReq || !clkEn);
	endproperty
	a_ext_pulse: assert property (p_ext_pulse) else $error("ext irq not one pulse"); // RQ3
	property p_ext1_mask;
		@(posedge clk_sys) disable iff (!arst_n)
		extInt1Req |-> $past(interruptMask1[`PFS_MASK1_EXT1]);
	endproperty
	a_ext1_mask: assert property (p_ext1_mask) else $error("masked ext1 fired"); // RQ8
	property p_nmi_vec;
		@(posedge clk_sys) disable iff (!arst_n)
		nmiReq |-> intVector == `PFS_VEC_NMI;
	endproperty
	a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector wrong"); // RQ6
	property p_wake;
		@(posedge clk_sys) disable iff (!arst_n)
		clkEn && powerDown && extSrcRise |=> wakeUp;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake"); // RQ5
	property p_stretch;
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(pinResetOe) && clkEn |-> pinResetOe [*8];
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch short"); // RQ10
	property p_tx_sel;
		@(posedge clk_sys) disable iff (!arst_n)
		clkEn && !ioControl1[`PFS_IO_CONTROL_1_TXD_EN] |=> pinTxOut == $past(portP2Out0);
	endproperty
	a_tx_sel: assert property (p_tx_sel) else $error("tx routing wrong"); // RQ13
	property p_hso_oe;
		@(posedge clk_sys) disable iff (!arst_n)
		clkEn |=> pinHsoOe[0] == $past(ioControl1[`PFS_IO_CONTROL_1_HSO4_EN]);
	endproperty
	a_hso_oe: assert property (p_hso_oe) else $error("hso4 enable wrong"); // RQ21
	property p_timer2_reset_input;
		@(posedge clk_sys) disable iff (!arst_n)
		timer2Reset |-> $past(ioControl0[`PFS_IO_CONTROL_0_TIMER2_RESET_INPUT_SEL]) && $past(syncRise[4]);
	endproperty
	a_timer2_reset_input: assert property (p_timer2_reset_input) else $error("timer2 reset uncaused"); // RQ19
	property p_ext_p07;
		@(posedge clk_sys) disable iff (!arst_n)
		clkEn && ioControl1[`PFS_IO_CONTROL_1_EXT_SEL] && syncRise[1] |=> extIntReq;
	endproperty
	a_ext_p07: assert property (p_ext_p07) else $error("port0 source lost"); // RQ1
	property p_ext_p22;
		@(posedge clk_sys) disable iff (!arst_n)
		clkEn && !ioControl1[`PFS_IO_CONTROL_1_EXT_SEL] && syncRise[2] |=> extIntReq;
	endproperty
	a_ext_p22: assert property (p_ext_p22) else $error("port2 source lost"); // RQ2
	property p_hsi0_mask;
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(hsi0IntReq) |-> $past(interruptMask[`PFS_MASK_HSI0]);
	endproperty
	a_hsi0_mask: assert property (p_hsi0_mask) else $error("masked hsi0 fired"); // RQ17
	property p_pulse_output_1_route;
		@(posedge clk_sys) disable iff (!arst_n)
		clkEn && ioControl3[`PFS_IO_CONTROL_3_PULSE_OUTPUT_1_EN] |=> pinP1Out[0] == $past(pulse_output_1);
	endproperty
	a_pulse_output_1_route: assert property (p_pulse_output_1_route) else $error("pulse_output_1 routing wrong"); // RQ15
	property p_rx_off;
		@(posedge clk_sys) disable iff (!arst_n)
		clkEn && !serialControl[`PFS_SERIAL_CONTROL_RXD_EN] |=> !rxData && !pinRxOe;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receive active while port"); // RQ11
	property p_timer2_clock_input;
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(timer2ClkTick) |-> $past(ioControl0[`PFS_IO_CONTROL_0_TIMER2_CLOCK_INPUT_SEL])
			&& !$past(ioControl3[`PFS_IO_CONTROL_3_T2_INTCLK]);
	endproperty
	a_timer2_clock_input: assert property (p_timer2_clock_input) else $error("timer2 clock uncaused"); // RQ20
	property p_oe_in_reset;
		@(posedge clk_sys) disable iff (!arst_n)
		pinResetOe |-> coreReset;
	endproperty
	a_oe_in_reset: assert property (p_oe_in_reset) else $error("pin pulled outside reset"); // RQ10
	property p_hsi3_en;
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(hsiEvent[3]) |-> $past(ioControl0[`PFS_IO_CONTROL_0_HSI3_EN]);
	endproperty
	a_hsi3_en: assert property (p_hsi3_en) else $error("hsi3 event while disabled"); // RQ18
endmodule

// File: hdl/pfs_pkg.sv
// types shared by the pin function select block
// assumes the defines header is compiled alongside
package pfs_pkg;
	typedef enum logic [1:0] {
		PFS_RST_COLD,
		PFS_RST_STRETCH,
		PFS_RST_RUN
	} pfs_rst_e;
	typedef logic [15:0] pfs_vec_t;
endpackage
